// File: prescaler_params.svh
// Offsets, field positions, reset values and tap counts of the prescaler
`ifndef PRESCALER_PARAMS_SVH
`define PRESCALER_PARAMS_SVH

`define OFS_SYNC_CONTROL   8'h00
`define OFS_SOURCE_SELECT  8'h04
`define OFS_STATUS         8'h08

`define BIT_SYNC_HOLD      7
`define BIT_CAPTURE_CHOICE 6
`define BIT_DIVIDER_RESET  0

`define SEL_T1_LSB         4

`define RST_SYNC_CONTROL   8'h00
`define RST_SOURCE_SELECT  8'h00

`define SRC_STOP           3'h0
`define SRC_SYSTEM         3'h1
`define SRC_DIV8           3'h2
`define SRC_DIV64          3'h3
`define SRC_DIV256         3'h4
`define SRC_DIV1024        3'h5
`define SRC_EXT_FALL       3'h6
`define SRC_EXT_RISE       3'h7

`define TAP_BITS_DIV8      3
`define TAP_BITS_DIV64     6
`define TAP_BITS_DIV256    8
`define TAP_BITS_DIV1024   10

`define STAT_PIN_LSB       16

`define HTRANS_NONSEQ      2'h2

`endif

// File: prescaler_pkg.sv
// Types shared by the timer prescaler and its bench
package prescaler_pkg;

  typedef logic [2:0] src_sel_t;

  typedef struct packed {
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
  } ahb_addr_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  offset;
  } data_phase_t;

  typedef struct packed {
    logic        sync_hold;
    logic        capture_choice;
    logic        divider_reset;
  } sync_ctrl_t;

endpackage

// File: shared_timer_prescaler.sv
// Shared timer prescaler, count pin sampling and capture routing
//
// Contract
// - Select one gives a tick every system cycle while divider reset is clear
// - Four taps divide by 8, 64, 256, 1024
// - One free divider shared by both timers
// - First prescaled tick within 1 to N+1 cycles
// - Divider reset restarts period for both timers
// - Pin sampled by latch and rising flops
// - Rising edge on seven, falling on six
// - Pin edge to tick 1.5 to 2.5 cycles
// - External pin edges never pass the divider
// - Hold bit keeps divider reset as written
// - Clearing hold loads divider reset as written, then it self clears
// - Divider reset bit self clears unless held
// - Choice bit routes capture pin to timer one
// - Select zero gives no ticks
`timescale 1ns/1ps
`include "prescaler_params.svh"

module shared_timer_prescaler
  import prescaler_pkg::*;
#(
  parameter int NUM_TIMERS = 2,
  parameter int DIV_WIDTH  = 10
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [NUM_TIMERS-1:0] external_count_pin,
  input  wire logic                  first_capture_pin,
  input  wire logic                  alternate_capture_pin,
  output logic      [NUM_TIMERS-1:0] timer_tick,
  output logic                       capture_trigger
);

  generate
    if (NUM_TIMERS != 2) begin : g_bad_timers
      $error("shared_timer_prescaler serves exactly two timers");
    end
    if (DIV_WIDTH != `TAP_BITS_DIV1024) begin : g_bad_width
      $error("shared_timer_prescaler divider must be ten bits");
    end
  endgenerate

  ahb_addr_t               addr_in;
  data_phase_t             dphase_ff;
  data_phase_t             nxt_dphase;
  sync_ctrl_t              ctrl_ff;
  logic [7:0]              src_sel_ff;
  logic [DIV_WIDTH-1:0]    div_cnt_ff;
  logic [31:0]             hrdata_ff;
  logic [31:0]             nxt_rdata;
  logic                    capture_ff;
  logic [NUM_TIMERS-1:0]   tick_ff;
  logic [NUM_TIMERS-1:0]   pin_latch;
  logic [NUM_TIMERS-1:0]   pin_samp_ff;
  logic [NUM_TIMERS-1:0]   pin_prev_ff;
  logic                    wr_ctrl;
  logic                    wr_src;
  logic                    tap8;
  logic                    tap64;
  logic                    tap256;
  logic                    tap1024;

  assign addr_in.htrans = htrans;
  assign addr_in.haddr  = haddr;
  assign addr_in.hwrite = hwrite;
  assign addr_in.hsize  = hsize;
  assign addr_in.hsel   = hsel;

  // Address phase capture; only word offsets decode
  always_comb begin
    nxt_dphase.valid  = addr_in.hsel && hready &&
                        (addr_in.htrans == `HTRANS_NONSEQ);
    nxt_dphase.write  = addr_in.hwrite;
    nxt_dphase.offset = addr_in.haddr[7:0];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dphase_ff <= '0;
    end else if (hready) begin
      dphase_ff <= nxt_dphase;
    end
  end

  assign wr_ctrl = dphase_ff.valid && dphase_ff.write &&
                   (dphase_ff.offset == `OFS_SYNC_CONTROL);
  assign wr_src  = dphase_ff.valid && dphase_ff.write &&
                   (dphase_ff.offset == `OFS_SOURCE_SELECT);

  // Zero wait states keep the bus simple; answer is always OKAY
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data built at the address edge so hrdata leaves a flop
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (nxt_dphase.valid && !nxt_dphase.write) begin
      case (nxt_dphase.offset)
        `OFS_SYNC_CONTROL: begin
          nxt_rdata[`BIT_SYNC_HOLD]      = ctrl_ff.sync_hold;
          nxt_rdata[`BIT_CAPTURE_CHOICE] = ctrl_ff.capture_choice;
          nxt_rdata[`BIT_DIVIDER_RESET]  = ctrl_ff.divider_reset;
        end
        `OFS_SOURCE_SELECT: begin
          nxt_rdata[7:0] = src_sel_ff;
        end
        `OFS_STATUS: begin
          nxt_rdata[DIV_WIDTH-1:0] = div_cnt_ff;
          nxt_rdata[`STAT_PIN_LSB +: NUM_TIMERS] = pin_samp_ff;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (hready) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  assign hrdata = hrdata_ff;

  // Hold and capture choice bits follow software directly
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff.sync_hold      <= 1'(`RST_SYNC_CONTROL >> `BIT_SYNC_HOLD);
      ctrl_ff.capture_choice <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_ff.sync_hold      <= hwdata[`BIT_SYNC_HOLD];
      ctrl_ff.capture_choice <= hwdata[`BIT_CAPTURE_CHOICE];
    end
  end

  // Divider reset: written value, then cleared unless held
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff.divider_reset <= 1'b0;
    end else if (wr_ctrl) begin
      // hold written zero clears reset after its one pulse
      ctrl_ff.divider_reset <= hwdata[`BIT_DIVIDER_RESET];
    end else if (!ctrl_ff.sync_hold) begin
      ctrl_ff.divider_reset <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_sel_ff <= `RST_SOURCE_SELECT;
    end else if (wr_src) begin
      src_sel_ff <= {1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
    end
  end

  // one free running divider for both timers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_ff <= '0;
    end else if (ctrl_ff.divider_reset) begin
      div_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  // taps fire once per divisor period
  always_comb begin
    tap8    = &div_cnt_ff[`TAP_BITS_DIV8-1:0];
    tap64   = &div_cnt_ff[`TAP_BITS_DIV64-1:0];
    tap256  = &div_cnt_ff[`TAP_BITS_DIV256-1:0];
    tap1024 = &div_cnt_ff[`TAP_BITS_DIV1024-1:0];
  end

  // pin latch open while the clock is high
  always_latch begin
    if (sys_clk) begin
      pin_latch <= external_count_pin;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_samp_ff <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_samp_ff <= pin_latch;
      pin_prev_ff <= pin_samp_ff;
    end
  end

  genvar t;
  generate
    for (t = 0; t < NUM_TIMERS; t++) begin : g_timer
      src_sel_t sel;
      logic     rise;
      logic     fall;
      logic     nxt_tick;

      assign sel  = src_sel_t'(src_sel_ff[t*`SEL_T1_LSB +: 3]);
      assign rise = pin_samp_ff[t] && !pin_prev_ff[t];
      assign fall = !pin_samp_ff[t] && pin_prev_ff[t];

      // Internal sources halt while the divider sits in reset
      always_comb begin
        nxt_tick = 1'b0;
        case (sel)
          `SRC_STOP: begin
            nxt_tick = 1'b0;
          end
          `SRC_SYSTEM: begin
            nxt_tick = !ctrl_ff.divider_reset;
          end
          // tap choice, phase set by shared divider
          `SRC_DIV8: begin
            nxt_tick = tap8 && !ctrl_ff.divider_reset;
          end
          `SRC_DIV64: begin
            nxt_tick = tap64 && !ctrl_ff.divider_reset;
          end
          `SRC_DIV256: begin
            nxt_tick = tap256 && !ctrl_ff.divider_reset;
          end
          `SRC_DIV1024: begin
            nxt_tick = tap1024 && !ctrl_ff.divider_reset;
          end
          `SRC_EXT_FALL: begin
            nxt_tick = fall;
          end
          `SRC_EXT_RISE: begin
            nxt_tick = rise;
          end
          default: begin
            nxt_tick = 1'b0;
          end
        endcase
      end

      // registered tick ends the pin delay
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          tick_ff[t] <= 1'b0;
        end else begin
          tick_ff[t] <= nxt_tick;
        end
      end
    end
  endgenerate

  assign timer_tick = tick_ff;

  // capture source for the second timer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_ff <= 1'b0;
    end else begin
      capture_ff <= ctrl_ff.capture_choice ? alternate_capture_pin
                                           : first_capture_pin;
    end
  end

  assign capture_trigger = capture_ff;

endmodule

// File: prescaler_sva.sv
// Port checker for the shared timer prescaler
`timescale 1ns/1ps
module prescaler_sva
  import prescaler_pkg::*;
#(
  parameter int NUM_TIMERS = 2,
  parameter int DIV_WIDTH  = 10
) (
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [NUM_TIMERS-1:0] external_count_pin,
  input wire logic                  first_capture_pin,
  input wire logic                  alternate_capture_pin,
  input wire logic [NUM_TIMERS-1:0] timer_tick,
  input wire logic                  capture_trigger
);
  logic       wr_ff;
  logic [7:0] ofs_ff;
  logic [7:0] ctl_ff;
  logic [7:0] sel_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff  <= 1'b0;
      ofs_ff <= 8'h00;
    end else if (hready) begin
      wr_ff  <= hsel && hwrite && htrans == 2'h2;
      ofs_ff <= haddr[7:0];
    end
  end
  // Mirror only; a select write right after a reset bit is not modelled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_ff <= 8'h00;
      sel_ff <= 8'h00;
    end else if (wr_ff && hready && ofs_ff == 8'h00) begin
      ctl_ff <= hwdata[7:0] & 8'hC1;
    end else if (wr_ff && hready && ofs_ff == 8'h04) begin
      sel_ff <= hwdata[7:0] & 8'h77;
    end else if (!ctl_ff[7]) begin
      ctl_ff[0] <= 1'b0;
    end
  end
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_sys_tick:
    assert property ($past(sel_ff[2:0]) == 3'h1 && !$past(ctl_ff[0])
      |-> timer_tick[0]) else $error("system tick missing");
  a_stop_quiet:
    assert property ($past(sel_ff[2:0]) == 3'h0 |-> !timer_tick[0])
      else $error("tick while stopped");
  a_tick_gap:
    assert property (timer_tick[0] && $past(sel_ff[2:0]) == 3'h2
      |=> !timer_tick[0] [*7]) else $error("divide by 8 tick early");
  a_sync_start:
    assert property ($fell(ctl_ff[0]) && sel_ff[2:0] == 3'h2
      |-> !timer_tick[0] [*7] ##[1:2] timer_tick[0])
      else $error("first tick after release off");
  a_rise_tick:
    assert property ($rose(external_count_pin[0]) && sel_ff[2:0] == 3'h7
      |-> ##2 timer_tick[0]) else $error("rising edge tick missing");
  a_fall_tick:
    assert property ($fell(external_count_pin[1]) && sel_ff[6:4] == 3'h6
      |-> ##2 timer_tick[1]) else $error("falling edge tick missing");
  a_edge_only:
    assert property (timer_tick[0] && sel_ff[2:0] == 3'h7
      && $past(sel_ff[2:0], 4) == 3'h7 |-> $past(external_count_pin[0], 2)
      && !$past(external_count_pin[0], 3)) else $error("tick with no edge");
  a_capture_route:
    assert property ($past(rst_b) |-> capture_trigger == ($past(ctl_ff[6])
      ? $past(alternate_capture_pin) : $past(first_capture_pin)))
      else $error("capture routed wrong");
endmodule
bind shared_timer_prescaler prescaler_sva #(
  .NUM_TIMERS(NUM_TIMERS), .DIV_WIDTH(DIV_WIDTH)
) u_sva (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .external_count_pin, .first_capture_pin,
  .alternate_capture_pin, .timer_tick, .capture_trigger);

// File: ext_clock_source.sv
// External clock source driving one count pin
`timescale 1ns/1ps
module ext_clock_source #(
  parameter int HALF = 2
) (
  input  wire logic sys_clk,
  input  wire logic enable,
  output logic      pin
);
  int cnt = 0;
  initial pin = 1'b0;
  always @(posedge sys_clk) begin
    if (enable) begin
      cnt <= (cnt + 1) % HALF;
      if (cnt == HALF - 1) begin
        pin <= ~pin;
      end
    end
  end
endmodule

// File: tb_top.sv
// Self-checking bench for the shared timer prescaler
`timescale 1ns/1ps
module tb_top
  import prescaler_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  ahb_addr_t   ap = '0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rv;
  logic [1:0]  src_en = 2'h0;
  logic        first_capture_pin = 1'b0;
  logic        alternate_capture_pin = 1'b0;
  wire  [1:0]  external_count_pin;
  wire  [1:0]  timer_tick;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         capture_trigger;
  int          failures = 0;
  int          check_count = 0;
  int          c0;
  int          c1;
  int          e0;
  int          e1;
  int          dv[4] = '{8, 64, 256, 1024};
  always #2.5 sys_clk = ~sys_clk;
  shared_timer_prescaler dut (
    .sys_clk, .rst_b, .hsel(ap.hsel), .haddr(ap.haddr),
    .htrans(ap.htrans), .hwrite(ap.hwrite), .hsize(ap.hsize), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
    .external_count_pin, .first_capture_pin, .alternate_capture_pin,
    .timer_tick, .capture_trigger);
  ext_clock_source #(.HALF(2)) src0 (.sys_clk, .enable(src_en[0]),
    .pin(external_count_pin[0]));
  ext_clock_source #(.HALF(5)) src1 (.sys_clk, .enable(src_en[1]),
    .pin(external_count_pin[1]));
  task automatic conclude();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    ap <= '{2'h2, {24'h0, a}, w, 3'h2, 1'b1};
    wait_rdy();
    ap <= '0;
    hwdata <= wd;
    wait_rdy();
    rv = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(rv, x);
  endtask
  // Ticks and pin edges per cycle; sampled mid-cycle
  task automatic count(input int n, input bit add);
    logic [1:0] pp;
    pp = external_count_pin;
    if (!add) begin
      c0 = 0;
      c1 = 0;
      e0 = 0;
      e1 = 0;
    end
    @(posedge sys_clk);
    repeat (n) begin
      @(negedge sys_clk);
      c0 += int'(timer_tick[0] === 1'b1);
      c1 += int'(timer_tick[1] === 1'b1);
      e0 += int'(external_count_pin[0] === 1'b1 && pp[0] === 1'b0);
      e1 += int'(external_count_pin[1] === 1'b0 && pp[1] === 1'b1);
      pp = external_count_pin;
    end
    @(posedge sys_clk);
  endtask
  task automatic t_regs();
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    xfer(1'b1, 8'h00, 32'hFFFF_FFFF);
    rdchk(8'h00, 32'hC1);
    xfer(1'b1, 8'h00, 32'h0);
    rdchk(8'h00, 32'h0);
    xfer(1'b1, 8'h00, 32'h1);
    // Reset bit stands for one cycle before it clears
    @(posedge sys_clk);
    rdchk(8'h00, 32'h0);
    xfer(1'b1, 8'h0C, 32'hFF);
    rdchk(8'h0C, 32'h0);
  endtask
  task automatic t_taps();
    xfer(1'b1, 8'h04, 32'h11);
    count(16, 1'b0);
    chk(c0 + c1, 32);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, 8'h04, {25'h0, 3'(2 + (s + 1) % 4), 1'b0, 3'(2 + s)});
      count(2048, 1'b0);
      chk(c0, 2048 / dv[s]);
      chk(c1, 2048 / dv[(s + 1) % 4]);
    end
    xfer(1'b1, 8'h04, 32'h0);
    count(64, 1'b0);
    chk(c0 + c1, 0);
  endtask
  task automatic t_sync();
    int f0 = 0;
    int f1 = 0;
    xfer(1'b1, 8'h04, 32'h32);
    xfer(1'b1, 8'h00, 32'h81);
    count(300, 1'b0);
    chk(c0 + c1, 0);
    xfer(1'b1, 8'h00, 32'h0);
    for (int i = 1; i <= 80; i++) begin
      @(negedge sys_clk);
      if (f0 == 0 && timer_tick[0] === 1'b1) f0 = i;
      if (f1 == 0 && timer_tick[1] === 1'b1) f1 = i;
    end
    @(posedge sys_clk);
    chk(f1 - f0, 56);
    chk(f0 >= 1 && f0 <= 9, 1);
  endtask
  task automatic t_ext();
    xfer(1'b1, 8'h04, 32'h67);
    // pins stand still while the source is switched
    src_en <= 2'h3;
    count(150, 1'b0);
    src_en <= 2'h0;
    count(10, 1'b1);
    chk(c0, e0);
    chk(c1, e1);
  endtask
  task automatic t_cap();
    for (int i = 0; i < 8; i++) begin
      {first_capture_pin, alternate_capture_pin} <= 2'(i);
      xfer(1'b1, 8'h00, {25'h0, i[2], 6'h0});
      repeat (2) @(negedge sys_clk);
      chk(capture_trigger, i[2] ? i[0] : i[1]);
      @(posedge sys_clk);
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_taps();
    t_sync();
    t_ext();
    t_cap();
    conclude();
  end
endmodule
